// ### core/pkg_match_pkg.sv
package pkg_match_pkg;

    // widths
    localparam int NUM_MATCH = 8;
    localparam int NUM_OUT   = 8;
    localparam int CNT_W     = 32;
    localparam int RUN_W     = 8;

    // register byte offsets
    localparam logic [11:0] CTRL_OFFS     = 12'h000;
    localparam logic [11:0] SELECT_OFFS   = 12'h004;
    localparam logic [11:0] OUTSET_OFFS   = 12'h008;
    localparam logic [11:0] RUNLEN_OFFS   = 12'h00c;
    localparam logic [11:0] INITVAL_OFFS  = 12'h010;
    localparam logic [11:0] ROLLVAL_OFFS  = 12'h014;
    localparam logic [11:0] COUNT_OFFS    = 12'h018;
    localparam logic [11:0] STATUS_OFFS   = 12'h01c;
    localparam logic [11:0] IRQMASK_OFFS  = 12'h020;
    localparam logic [11:0] OUTSTATE_OFFS = 12'h024;
    localparam logic [11:0] ACTION_OFFS   = 12'h028;

    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DISABLE  = 4;
    localparam int CTRL_AT_MATCH = 5;
    localparam int CTRL_DOWN     = 6;
    localparam int ACT_RELOAD    = 0;
    localparam int ACT_OUT_CLEAR = 1;

    // status bits
    localparam int ST_FIRE  = 0;
    localparam int ST_OUTON = 1;
    localparam int ST_ROLL  = 2;

    // reset values
    localparam logic [31:0]      CTRL_RST    = 32'h0000_0000;
    localparam logic [NUM_MATCH-1:0] SELECT_RST = 8'h01;
    localparam logic [NUM_OUT-1:0]   OUTSET_RST = 8'h01;
    localparam logic [RUN_W-1:0]     RUNLEN_RST = 8'h01;
    localparam logic [CNT_W-1:0]     INIT_RST   = 32'h0000_0000;
    localparam logic [CNT_W-1:0]     ROLL_RST   = 32'h7735_9400;

    typedef enum logic [2:0] {
        MODE_READ,
        MODE_NOREAD,
        MODE_MATCH,
        MODE_READ_NOMATCH,
        MODE_NOREAD_OR_NOMATCH,
        MODE_NOMATCH
    } pkg_mode_t;

    // per-cycle events from decoder, match table and trigger
    typedef struct packed {
        logic                 trigEnd;
        logic                 decodeValid;
        logic [NUM_MATCH-1:0] decoded;
        logic [NUM_MATCH-1:0] satisfied;
    } match_ev_t;

endpackage : pkg_match_pkg

// ### core/package_match_output_logic.sv
`timescale 1ns/10ps
`default_nettype none

module package_match_output_logic
    import pkg_match_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire match_ev_t          matchEv,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic [NUM_OUT-1:0]      discreteOut,
    output logic                    irq
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0]          ctrl;
    logic [NUM_MATCH-1:0] selectMask;
    logic [NUM_OUT-1:0]   outSet;
    logic [RUN_W-1:0]     runLen;
    logic [CNT_W-1:0]     initVal;
    logic [CNT_W-1:0]     rollVal;
    logic [CNT_W-1:0]     count;
    logic [2:0]           status;
    logic [2:0]           irqMask;
    logic [RUN_W-1:0]     runCount;
    logic [NUM_MATCH-1:0] seenDecoded;
    logic [NUM_MATCH-1:0] seenSatisfied;
    logic                 seenRead;
    logic                 firedInWindow;
    logic                 countedInWindow;
    logic                 reloadReq;
    logic                 outClearReq;

    pkg_mode_t mode;
    logic      disabled;
    logic      atMatch;
    logic      wrEn;
    logic      rdEn;
    logic      addrOk;

    assign mode     = pkg_mode_t'(ctrl[CTRL_MODE_LSB +: 3]);
    assign disabled = ctrl[CTRL_DISABLE];
    assign atMatch  = ctrl[CTRL_AT_MATCH];
    assign wrEn     = psel && penable && pwrite;
    assign rdEn     = psel && !penable && !pwrite;
    assign addrOk   = (paddr <= ACTION_OFFS) && (paddr[1:0] == 2'b00);

    ////////////////////////////////////////////////////////////////////////
    // evaluation: accumulate over the trigger window
    logic [NUM_MATCH-1:0] decAcc;
    logic [NUM_MATCH-1:0] satAcc;
    logic                 allDecoded;
    logic                 allSatisfied;
    logic                 validRead;
    logic                 readNow;
    logic                 noRead;
    logic                 noMatch;
    logic                 cond;
    logic                 evalPoint;
    logic                 fire;
    logic                 miss;

    assign decAcc       = seenDecoded | (matchEv.decodeValid ? matchEv.decoded : '0);
    assign satAcc       = seenSatisfied | (matchEv.decodeValid ? matchEv.satisfied : '0);
    assign allDecoded   = ((decAcc & selectMask) == selectMask);
    assign allSatisfied = ((satAcc & selectMask) == selectMask);
    assign validRead    = allSatisfied;
    assign readNow      = seenRead || matchEv.decodeValid;
    assign noRead       = matchEv.trigEnd && !validRead;
    assign noMatch      = readNow && !allSatisfied;

    // condition per mode; at-match timing in read and match modes evaluates on each decode until one fires
    always_comb begin
        cond = 1'b0;
        case (mode)
            MODE_READ:              cond = allDecoded;
            MODE_NOREAD:            cond = noRead;
            MODE_MATCH:             cond = allSatisfied;
            MODE_READ_NOMATCH:      cond = readNow && allDecoded && !allSatisfied;
            MODE_NOREAD_OR_NOMATCH: cond = noRead || (matchEv.trigEnd && noMatch);
            MODE_NOMATCH:           cond = noMatch;
            default:                cond = 1'b0;
        endcase
    end

    // no-read style modes can only be judged at trigger end
    always_comb begin
        evalPoint = matchEv.trigEnd;
        if (atMatch && (mode == MODE_READ || mode == MODE_MATCH)) begin
            evalPoint = matchEv.decodeValid && !firedInWindow;
        end
    end

    assign fire = !disabled && evalPoint && cond;
    assign miss = !disabled && matchEv.trigEnd && !cond && !firedInWindow;

    // window accumulators, cleared at trigger end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            seenDecoded   <= '0;
            seenSatisfied <= '0;
            seenRead      <= 1'b0;
            firedInWindow <= 1'b0;
        end else if (matchEv.trigEnd) begin
            seenDecoded   <= '0;
            seenSatisfied <= '0;
            seenRead      <= 1'b0;
            firedInWindow <= 1'b0;
        end else begin
            seenDecoded   <= decAcc;
            seenSatisfied <= satAcc;
            seenRead      <= readNow;
            if (fire) begin
                firedInWindow <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // consecutive-run qualifier and outputs
    logic runDone;
    assign runDone = fire && ({1'b0, runCount} + 9'd1 >= {1'b0, runLen});

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            runCount <= '0;
        end else if (miss) begin
            runCount <= '0;
        end else if (fire && runCount != '1) begin
            runCount <= runCount + 8'h01;
        end
    end

    // outputs latch on; software clears them
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            discreteOut <= '0;
        end else if (runDone) begin
            discreteOut <= discreteOut | outSet;
        end else if (outClearReq) begin
            discreteOut <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // package counter
    logic countStep;
    logic atRoll;
    assign countStep = !disabled && validRead && !countedInWindow && matchEv.decodeValid;
    assign atRoll    = (count == rollVal);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            countedInWindow <= 1'b0;
        end else if (matchEv.trigEnd) begin
            countedInWindow <= 1'b0;
        end else if (countStep) begin
            countedInWindow <= 1'b1;
        end
    end

    // power-up value is the initial value reset constant
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count <= INIT_RST;
        end else if (reloadReq) begin
            count <= initVal;
        end else if (countStep) begin
            if (atRoll) begin
                count <= initVal;
            end else if (ctrl[CTRL_DOWN]) begin
                count <= count - 32'h0000_0001;
            end else begin
                count <= count + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status, write one to clear, set wins
    logic [2:0] evBits;
    logic [2:0] clrBits;
    assign evBits  = {countStep && atRoll, runDone, fire};
    assign clrBits = (wrEn && paddr == STATUS_OFFS) ? pwdata[2:0] : 3'b000;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            status <= 3'b000;
            irq    <= 1'b0;
        end else begin
            status <= (status & ~clrBits) | evBits;
            irq    <= |(((status & ~clrBits) | evBits) & irqMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb writes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl        <= CTRL_RST;
            selectMask  <= SELECT_RST;
            outSet      <= OUTSET_RST;
            runLen      <= RUNLEN_RST;
            initVal     <= INIT_RST;
            rollVal     <= ROLL_RST;
            irqMask     <= 3'b000;
            reloadReq   <= 1'b0;
            outClearReq <= 1'b0;
        end else begin
            reloadReq   <= 1'b0;
            outClearReq <= 1'b0;
            if (wrEn) begin
                if (paddr == CTRL_OFFS) begin
                    ctrl <= {25'h0, pwdata[6:0]};
                end else if (paddr == SELECT_OFFS) begin
                    selectMask <= pwdata[NUM_MATCH-1:0];
                end else if (paddr == OUTSET_OFFS) begin
                    outSet <= pwdata[NUM_OUT-1:0];
                end else if (paddr == RUNLEN_OFFS) begin
                    runLen <= pwdata[RUN_W-1:0];
                end else if (paddr == INITVAL_OFFS) begin
                    initVal <= pwdata;
                end else if (paddr == ROLLVAL_OFFS) begin
                    rollVal <= pwdata;
                end else if (paddr == IRQMASK_OFFS) begin
                    irqMask <= pwdata[2:0];
                end else if (paddr == ACTION_OFFS) begin
                    reloadReq   <= pwdata[ACT_RELOAD];                          // first run of application
                    outClearReq <= pwdata[ACT_OUT_CLEAR];
                end
            end
        end
    end

    // apb read data captured in setup, no wait state
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (rdEn) begin
            if (paddr == CTRL_OFFS) begin
                prdata <= ctrl;
            end else if (paddr == SELECT_OFFS) begin
                prdata <= {24'h0, selectMask};
            end else if (paddr == OUTSET_OFFS) begin
                prdata <= {24'h0, outSet};
            end else if (paddr == RUNLEN_OFFS) begin
                prdata <= {24'h0, runLen};
            end else if (paddr == INITVAL_OFFS) begin
                prdata <= initVal;
            end else if (paddr == ROLLVAL_OFFS) begin
                prdata <= rollVal;
            end else if (paddr == COUNT_OFFS) begin
                prdata <= count;
            end else if (paddr == STATUS_OFFS) begin
                prdata <= {29'h0, status};
            end else if (paddr == IRQMASK_OFFS) begin
                prdata <= {29'h0, irqMask};
            end else if (paddr == OUTSTATE_OFFS) begin
                prdata <= {16'h0, runCount, discreteOut};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ready in access cycle; error flags unmapped addresses
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addrOk;
        end
    end

endmodule : package_match_output_logic

`default_nettype wire

// ### verif/match_out_checker.sv
`timescale 1ns/10ps
`default_nettype none
module match_out_checker
    import pkg_match_pkg::*;
(
    input wire logic               ref_clk,
    input wire logic               resetn,
    input wire match_ev_t          matchEv,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [NUM_OUT-1:0] discreteOut,
    input wire logic               irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    // helper terms
    wire logic evAny   = matchEv.trigEnd | matchEv.decodeValid;
    wire logic wrAny   = psel & penable & pwrite;
    wire logic badAddr = (paddr > ACTION_OFFS) || (paddr[1:0] != 2'h0);
    wire logic clrWr   = wrAny & (paddr == ACTION_OFFS) & pwdata[ACT_OUT_CLEAR];
    sequence setupSeq;
        psel && !penable;
    endsequence
    sequence answerSeq;
        pready ##1 !pready;
    endsequence
    ////////////////////////////////////////////////////////////////
    // bus answer timing and refusals
    answer_timing_a: assert property (setupSeq |=> answerSeq) else $error("pready not one cycle");
    bad_addr_a: assert property (psel && !penable && badAddr |=> pready && pslverr) else $error("no slverr");
    good_addr_a: assert property (psel && !penable && !badAddr |=> !pslverr) else $error("stray slverr");
    err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("bad err data");
    // outputs move only after an event or a clear write
    out_cause_a: assert property ((discreteOut & ~$past(discreteOut)) != '0 |->
        $past(evAny) || $past(evAny, 2) || $past(evAny, 3)) else $error("output rose without event");
    out_clear_a: assert property ((~discreteOut & $past(discreteOut)) != '0 |->
        $past(clrWr) || $past(clrWr, 2)) else $error("output fell without clear");
    // irq follows status, which only events set and writes clear
    // status and irq load on the edge that takes the event; a mask write acts one edge later
    irq_cause_a: assert property ($rose(irq) |-> $past(evAny) || $past(wrAny)
        || $past(wrAny, 2)) else $error("irq rose without cause");
    irq_drop_a: assert property ($fell(irq) |-> $past(wrAny) || $past(wrAny, 2)) else $error("irq fell alone");
endmodule : match_out_checker
`default_nettype wire

// ### verif/event_source.sv
`timescale 1ns/10ps
`default_nettype none
module event_source
    import pkg_match_pkg::*;
(
    input wire logic      ref_clk,
    output var match_ev_t matchEv
);
    initial matchEv = '0;
    // one-cycle event; data flipped afterwards so stale values never look valid
    task automatic send(input logic te, input logic dv, input logic [7:0] d, input logic [7:0] s);
        @(posedge ref_clk);
        matchEv <= '{te, dv, d, s};
        @(posedge ref_clk);
        matchEv <= '{1'b0, 1'b0, ~d, ~s};
    endtask : send
endmodule : event_source
`default_nettype wire

// ### verif/package_match_output_logic_tb.sv
`timescale 1ns/10ps
`default_nettype none
module package_match_output_logic_tb
    import pkg_match_pkg::*;
;
    logic               ref_clk = 1'b0;
    logic               resetn  = 1'b0;
    logic               psel    = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite  = 1'b0;
    logic [11:0]        paddr   = 12'h000;
    logic [31:0]        pwdata  = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               irq;
    logic [NUM_OUT-1:0] discreteOut;
    match_ev_t          matchEv;
    logic [31:0]        rdat;
    logic               rerr;
    int                 n_errors = 0;
    int                 checks   = 0;
    // expected firing per mode, bits {no decode, partial match, full match}
    logic [2:0]         fireTab [6] = '{3'b011, 3'b110, 3'b001, 3'b010, 3'b110, 3'b010};
    always #2 ref_clk = ~ref_clk;
    package_match_output_logic package_match_output_logic_inst (.ref_clk(ref_clk), .resetn(resetn),
        .matchEv(matchEv), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .discreteOut(discreteOut), .irq(irq));
    event_source event_source_inst (.ref_clk(ref_clk), .matchEv(matchEv));
    ////////////////////////////////////////////////////////////////
    // access and compare tasks
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // master waits for pready, never assumes the slave's latency
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge ref_clk); while (pready !== 1'b1 && n++ < 20);
        // a slave that never answers counts as a mismatch
        if (pready !== 1'b1) n_errors++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(rdat, exp);
    endtask : rd
    // k: 0 full match, 1 partial match, 2 no decode; fixed settle wait
    task win(input int k);
        event_source_inst.send(1'b1, k != 2, 8'h03, k == 0 ? 8'h03 : 8'h01);
        repeat (4) @(posedge ref_clk);
    endtask : win
    task outIs(input logic [7:0] exp);
        #1 cmp({24'h0, discreteOut}, {24'h0, exp});
    endtask : outIs
    task print_verdict;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////
    // watchdog, far beyond the expected few hundred cycles
    initial begin
        #100000;
        n_errors++;
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(CTRL_OFFS, 32'h0); rd(SELECT_OFFS, 32'h1); rd(OUTSET_OFFS, 32'h1); rd(RUNLEN_OFFS, 32'h1);
        rd(INITVAL_OFFS, 32'h0); rd(ROLLVAL_OFFS, 32'h7735_9400); rd(COUNT_OFFS, 32'h0);
        apb(1'b0, 12'h02c, 32'h0);
        cmp({31'h0, rerr}, 32'h1);
        wr(SELECT_OFFS, 32'h3);
        wr(OUTSET_OFFS, 32'h5);
        // every mode against every kind of window
        for (int m = 0; m < 6; m++) begin
            for (int k = 0; k < 3; k++) begin
                wr(CTRL_OFFS, 32'(m));
                win(k);
                outIs(fireTab[m][k] ? 8'h05 : 8'h00);
                wr(ACTION_OFFS, 32'h2);
            end
        end
        wr(ACTION_OFFS, 32'h1);
        wr(CTRL_OFFS, 32'h12);
        win(0);
        outIs(8'h00);
        rd(COUNT_OFFS, 32'h0);
        // at-match timing fires before the window closes
        wr(CTRL_OFFS, 32'h22);
        event_source_inst.send(1'b0, 1'b1, 8'h03, 8'h03);
        repeat (3) @(posedge ref_clk);
        outIs(8'h05);
        event_source_inst.send(1'b1, 1'b0, 8'h00, 8'h00);
        wr(ACTION_OFFS, 32'h2);
        wr(CTRL_OFFS, 32'h2);
        event_source_inst.send(1'b0, 1'b1, 8'h03, 8'h03);
        repeat (3) @(posedge ref_clk);
        outIs(8'h00);
        win(2);
        outIs(8'h05);
        // run of three, broken once by a miss
        wr(ACTION_OFFS, 32'h2);
        wr(RUNLEN_OFFS, 32'h3);
        // leading miss clears the run left over from earlier firings
        win(2); win(0); win(0); win(2); win(0); win(0);
        outIs(8'h00);
        win(0);
        outIs(8'h05);
        // counting up through rollover, with the rollover interrupt
        wr(INITVAL_OFFS, 32'h5); wr(ROLLVAL_OFFS, 32'h7); wr(ACTION_OFFS, 32'h1);
        wr(STATUS_OFFS, 32'hffff_ffff); wr(IRQMASK_OFFS, 32'h4);
        rd(COUNT_OFFS, 32'h5);
        win(0); rd(COUNT_OFFS, 32'h6);
        win(0); rd(COUNT_OFFS, 32'h7);
        cmp({31'h0, irq}, 32'h0);
        win(0); rd(COUNT_OFFS, 32'h5);
        cmp({31'h0, irq}, 32'h1);
        wr(STATUS_OFFS, 32'h4);
        repeat (2) @(posedge ref_clk);
        #1 cmp({31'h0, irq}, 32'h0);
        wr(IRQMASK_OFFS, 32'h0);
        win(0); win(0); win(0);
        cmp({31'h0, irq}, 32'h0);
        // counting down wraps the same way
        wr(CTRL_OFFS, 32'h42); wr(ROLLVAL_OFFS, 32'h3); wr(ACTION_OFFS, 32'h1);
        win(0); rd(COUNT_OFFS, 32'h4);
        win(0); rd(COUNT_OFFS, 32'h3);
        win(0); rd(COUNT_OFFS, 32'h5);
        print_verdict;
    end
endmodule : package_match_output_logic_tb
bind package_match_output_logic match_out_checker match_out_checker_inst (.ref_clk(ref_clk), .resetn(resetn),
    .matchEv(matchEv), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .discreteOut(discreteOut), .irq(irq));
`default_nettype wire
